// ==== rbs_sequencer.sv ====
// Behaviour
// [R1] Merge all nine reset sources into reset
// [R2] Hold reset while supply below minimum
// [R3] Power-up timer gives nominal 64 ms
// [R4] Reset held while power-up timer counts
// [R5] Active-low config bit enables power-up timer
// [R6] Timer starts after power-on and brown-out release
// [R7] Config bit selects brown-out trip level
// [R8] Brown-out needs sustained low beyond filter delay
// [R9] Mode 11: always on, start waits ready
// [R10] Mode 11: wake-up not delayed
// [R11] Mode 10: off in sleep, start waits
// [R12] Mode 10: wake waits for brown-out ready
// [R13] Mode 01: software bit enables, no wait
// [R14] Software mode protects once circuit ready
// [R15] Sleep does not change software enable
// [R16] Mode 00 or software off: immediate start
// [R17] Forced-on ready adds no start delay
// [R18] Start needs timers expired and pin released
// [R19] Late pin release: run after 10 cycles
// [R20] Low-power brown-out ORed into brown-out
// [R21] Reset asserts at once, releases clocked
// [R22] Timer length is a cycle-count parameter
`timescale 1ns/1ps
module rbs_sequencer
    import rbs_pkg::*;
#(
    parameter int unsigned POWER_UP_TIMER_LEN = POWER_UP_TIMER_CYCLES,
    parameter int unsigned FILTER_LEN = BOR_FILTER_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire rbs_src_t src,
    input wire rbs_cfg_t cfg,
    input wire logic brownout_circuit_ready,
    input wire logic osc_startup_done,
    input wire logic sleep_active,
    input wire rbs_bus_t bus,
    output logic [DATA_W-1:0] rd_data,
    output logic core_reset,
    output logic exec_release,
    output logic brownout_enable,
    output logic brownout_trip_level,
    output logic bandgap_force
);

    // ----------------------------------------------------------------
    // Source decode
    // ----------------------------------------------------------------
    rbs_top_state_t s_q;
    rbs_top_state_t s_d;
    logic [1:0] mode;
    logic bor_active;
    logic bor_sample;
    logic bor_filtered;
    logic bor_any;
    logic hard_src;
    logic soft_src;
    logic pin_held;
    logic ost_ok;
    logic bor_start_ok;
    logic [NUM_CAUSE-1:0] cause_ev;
    logic [NUM_CAUSE-1:0] cause_clr;

    assign mode = cfg.brownout_mode_field;
    assign pin_held = cfg.ext_reset_enable & ~src.external_reset_pin_n;
    assign ost_ok = osc_startup_done | ~cfg.osc_startup_required;

    always_comb begin
        bor_active = 1'b0;
        unique case (mode)
            BOR_MODE_ON: bor_active = 1'b1; // [R9] [R10]
            BOR_MODE_AWAKE: bor_active = ~sleep_active; // [R11]
            BOR_MODE_SW: bor_active = s_q.sw_en; // [R13] [R15]
            BOR_MODE_OFF: bor_active = 1'b0; // [R16]
        endcase
    end

    // Protection only counts once the analog circuit is ready
    assign bor_sample = src.brownout_below & bor_active & brownout_circuit_ready; // [R14]

    rbs_filter #(
        .DELAY(FILTER_LEN)
    ) u_filter (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .in_level(bor_sample), // [R8]
        .out_level(bor_filtered)
    );

    assign bor_any = bor_filtered | (cfg.low_power_brownout_enable & src.low_power_brownout); // [R20]
    assign hard_src = ~src.por_ok | bor_any | src.prog_exit; // [R1] [R2]
    assign soft_src = pin_held | src.wdt_reset | src.reset_instr
        | (cfg.stack_reset_enable & (src.stack_overflow | src.stack_underflow)); // [R1]

    // Forced-on modes gate start on readiness and supply above trip, with no added delay
    assign bor_start_ok = (mode == BOR_MODE_ON || mode == BOR_MODE_AWAKE)
        ? (brownout_circuit_ready & ~src.brownout_below) : 1'b1; // [R9] [R11] [R13] [R16] [R17]

    // ----------------------------------------------------------------
    // Reset cause events
    // ----------------------------------------------------------------
    assign cause_ev[CAUSE_POR] = ~src.por_ok | src.prog_exit;
    assign cause_ev[CAUSE_BOR] = bor_any;
    assign cause_ev[CAUSE_PIN] = pin_held;
    assign cause_ev[CAUSE_WDT] = src.wdt_reset;
    assign cause_ev[CAUSE_INSTR] = src.reset_instr;
    assign cause_ev[CAUSE_OVF] = cfg.stack_reset_enable & src.stack_overflow;
    assign cause_ev[CAUSE_UNF] = cfg.stack_reset_enable & src.stack_underflow;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CAUSE; gi++) begin : g_clr
            assign cause_clr[gi] = bus.wr & (bus.addr == ADDR_CAUSE) & bus.wdata[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (hard_src) begin
            s_d.st = ST_HARD; // [R2]
            s_d.cnt = '0;
            s_d.pin_seen = 1'b0;
        end else begin
            unique case (s_q.st)
                ST_HARD: begin
                    s_d.cnt = '0;
                    if (!cfg.power_up_timer_enable_n) begin
                        s_d.st = ST_POWER_UP_TIMER; // [R5] [R6]
                    end else begin
                        s_d.st = ST_WAIT; // [R5]
                    end
                end
                ST_POWER_UP_TIMER: begin
                    if (s_q.cnt == POWER_UP_TIMER_W'(POWER_UP_TIMER_LEN - 1)) begin
                        s_d.st = ST_WAIT; // [R3] [R22]
                        s_d.cnt = '0;
                    end else begin
                        s_d.cnt = s_q.cnt + 1'b1; // [R4]
                    end
                end
                ST_WAIT: begin
                    if (ost_ok && bor_start_ok) begin
                        if (pin_held) begin
                            s_d.pin_seen = 1'b1; // [R18]
                        end else if (soft_src) begin
                            s_d.st = ST_WAIT;
                        end else if (s_q.pin_seen) begin
                            s_d.st = ST_PIN_DELAY; // [R19]
                            s_d.cnt = '0;
                        end else begin
                            s_d.st = ST_RUN; // [R18]
                        end
                    end
                end
                ST_PIN_DELAY: begin
                    if (soft_src) begin
                        s_d.st = ST_WAIT;
                    end else if (s_q.cnt == POWER_UP_TIMER_W'(PIN_DELAY_CYCLES - 1)) begin
                        s_d.st = ST_RUN; // [R19]
                        s_d.pin_seen = 1'b0;
                    end else begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (soft_src) begin
                        s_d.st = ST_WAIT; // [R1]
                        s_d.pin_seen = pin_held;
                    end
                end
                default: begin
                    s_d.st = ST_HARD;
                end
            endcase
        end

        // Wake from sleep in mode 10 waits for ready
        if (mode != BOR_MODE_AWAKE) begin
            s_d.wake_hold = 1'b0; // [R10]
        end else if (sleep_active) begin
            s_d.wake_hold = 1'b1; // [R12]
        end else if (brownout_circuit_ready) begin
            s_d.wake_hold = 1'b0;
        end

        // Register writes
        if (bus.wr && bus.addr == ADDR_BOR_CTRL) begin
            s_d.sw_en = bus.wdata[CTRL_SW_EN_BIT];
            s_d.fast = bus.wdata[CTRL_FAST_BIT];
        end
        // New cause beats a clear in the same cycle
        s_d.cause = (s_q.cause & ~cause_clr) | cause_ev;

        // Register reads, data valid only in the following cycle
        s_d.rdata = '0;
        if (bus.rd) begin
            if (bus.addr == ADDR_BOR_CTRL) begin
                s_d.rdata[CTRL_SW_EN_BIT] = s_q.sw_en;
                s_d.rdata[CTRL_FAST_BIT] = s_q.fast;
                s_d.rdata[CTRL_READY_BIT] = brownout_circuit_ready; // [R14]
            end else if (bus.addr == ADDR_CAUSE) begin
                s_d.rdata[NUM_CAUSE-1:0] = s_q.cause;
            end
        end

        // Outputs
        s_d.core_reset = (s_d.st != ST_RUN); // [R4] [R21]
        s_d.exec_release = (s_d.st == ST_RUN) & ~sleep_active
            & ~(s_d.wake_hold & ~brownout_circuit_ready); // [R12] [R16]
        s_d.bor_enable = bor_active;
        s_d.trip = cfg.brownout_trip_select; // [R7]
        s_d.bandgap_force = s_q.fast & (mode == BOR_MODE_AWAKE || mode == BOR_MODE_SW);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset sets core reset at once; release waits for a clock edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= TOP_RST; // [R21]
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rdata;
    assign core_reset = s_q.core_reset;
    assign exec_release = s_q.exec_release;
    assign brownout_enable = s_q.bor_enable;
    assign brownout_trip_level = s_q.trip;
    assign bandgap_force = s_q.bandgap_force;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset || !ce);

    sequence s_timers_done;
        ost_ok && bor_start_ok && !pin_held && !soft_src && !hard_src;
    endsequence

    sequence s_pin_last;
        s_q.st == ST_PIN_DELAY && s_q.cnt == POWER_UP_TIMER_W'(PIN_DELAY_CYCLES - 1);
    endsequence

    a_por_holds: assert property (!src.por_ok |=> core_reset && s_q.st == ST_HARD) // [R2]
        else $error("reset not held with supply low");
    a_power_up_timer_holds: assert property (s_q.st == ST_POWER_UP_TIMER |-> core_reset && !exec_release) // [R4]
        else $error("core released during power-up timer");
    a_power_up_timer_bound: assert property (s_q.st == ST_POWER_UP_TIMER |-> s_q.cnt < POWER_UP_TIMER_W'(POWER_UP_TIMER_LEN)) // [R3]
        else $error("power-up timer overran its length");
    a_power_up_timer_done: assert property (s_q.st == ST_POWER_UP_TIMER && s_q.cnt == POWER_UP_TIMER_W'(POWER_UP_TIMER_LEN - 1) && !hard_src
        |=> s_q.st == ST_WAIT) // [R22]
        else $error("power-up timer did not expire");
    a_power_up_timer_start: assert property ($rose(s_q.st == ST_POWER_UP_TIMER) |-> $past(src.por_ok) && !$past(bor_any)) // [R6]
        else $error("timer started during hard reset");
    a_power_up_timer_off: assert property (s_q.st == ST_HARD && !hard_src && cfg.power_up_timer_enable_n
        |=> s_q.st != ST_POWER_UP_TIMER) // [R5]
        else $error("disabled power-up timer ran");
    a_sources: assert property (src.wdt_reset || src.reset_instr || src.prog_exit |=> core_reset) // [R1]
        else $error("reset source ignored");
    a_lp_bor: assert property (cfg.low_power_brownout_enable && src.low_power_brownout
        |=> core_reset ##0 s_q.st == ST_HARD) // [R20]
        else $error("low-power brown-out not merged");
    a_mode_on: assert property (mode == BOR_MODE_ON |=> brownout_enable) // [R9]
        else $error("always-on brown-out disabled");
    a_mode_sleep: assert property (mode == BOR_MODE_AWAKE |=> brownout_enable == !$past(sleep_active)) // [R11]
        else $error("mode 10 enable wrong");
    a_mode_sw: assert property (mode == BOR_MODE_SW |=> brownout_enable == $past(s_q.sw_en)) // [R13] [R15]
        else $error("software enable not followed");
    a_mode_off: assert property (mode == BOR_MODE_OFF |=> !brownout_enable) // [R16]
        else $error("brown-out active in mode 00");
    a_sw_ready: assert property (!brownout_circuit_ready |-> !bor_sample) // [R14]
        else $error("protection before circuit ready");
    a_trip_sel: assert property (1'b1 |=> brownout_trip_level == $past(cfg.brownout_trip_select)) // [R7]
        else $error("trip select not passed");
    a_wake_hold: assert property ($fell(sleep_active) && mode == BOR_MODE_AWAKE && !brownout_circuit_ready
        |=> !exec_release) // [R12]
        else $error("wake not held for ready");
    a_wake_free: assert property (s_q.st == ST_RUN && mode == BOR_MODE_ON && !sleep_active && !hard_src
        && !soft_src |=> exec_release) // [R10] [R17]
        else $error("always-on mode delayed wake");
    a_start_gate: assert property ($rose(s_q.st == ST_RUN) |-> $past(ost_ok) && !$past(pin_held)) // [R18]
        else $error("start before timers or pin");
    a_pin_run: assert property (s_pin_last ##0 s_timers_done |=> s_q.st == ST_RUN ##1 exec_release
        || sleep_active) // [R19]
        else $error("late pin release delay wrong");
    a_pin_count: assert property ($rose(s_q.st == ST_PIN_DELAY) |-> s_q.cnt == '0 && core_reset) // [R19]
        else $error("pin delay count not restarted");
    a_filter_in: assert property ($rose(bor_filtered) |-> $past(bor_sample)) // [R8]
        else $error("brown-out without sustained low");
    a_reset_out: assert property (hard_src |=> core_reset ##1 core_reset || !hard_src) // [R21]
        else $error("core reset dropped under hard reset");

endmodule

// ==== rbs_pkg.sv ====
package rbs_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned CLK_KHZ = 10000;
    localparam int unsigned POWER_UP_TIMER_MS = 64;
    localparam int unsigned POWER_UP_TIMER_CYCLES = POWER_UP_TIMER_MS * CLK_KHZ;
    localparam int unsigned BOR_FILTER_NS = 1000;
    localparam int unsigned BOR_FILTER_CYCLES = (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PIN_DELAY_CYCLES = 10;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned POWER_UP_TIMER_W = 20;
    localparam int unsigned FILT_W = 8;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CAUSE = 7;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_BOR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE = 4'h1;
    localparam int unsigned CTRL_SW_EN_BIT = 7;
    localparam int unsigned CTRL_FAST_BIT = 6;
    localparam int unsigned CTRL_READY_BIT = 0;
    localparam logic CTRL_SW_EN_RST = 1'b1;
    localparam logic CTRL_FAST_RST = 1'b0;
    localparam logic [NUM_CAUSE-1:0] CAUSE_RST = 7'h01;
    localparam int unsigned CAUSE_POR = 0;
    localparam int unsigned CAUSE_BOR = 1;
    localparam int unsigned CAUSE_PIN = 2;
    localparam int unsigned CAUSE_WDT = 3;
    localparam int unsigned CAUSE_INSTR = 4;
    localparam int unsigned CAUSE_OVF = 5;
    localparam int unsigned CAUSE_UNF = 6;

    // ----------------------------------------------------------------
    // Brown-out modes
    // ----------------------------------------------------------------
    localparam logic [1:0] BOR_MODE_ON = 2'h3;
    localparam logic [1:0] BOR_MODE_AWAKE = 2'h2;
    localparam logic [1:0] BOR_MODE_SW = 2'h1;
    localparam logic [1:0] BOR_MODE_OFF = 2'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {ST_HARD, ST_POWER_UP_TIMER, ST_WAIT, ST_PIN_DELAY, ST_RUN} rbs_state_t;

    typedef struct packed {
        logic por_ok;
        logic brownout_below;
        logic low_power_brownout;
        logic external_reset_pin_n;
        logic wdt_reset;
        logic reset_instr;
        logic stack_overflow;
        logic stack_underflow;
        logic prog_exit;
    } rbs_src_t;

    typedef struct packed {
        logic power_up_timer_enable_n;
        logic [1:0] brownout_mode_field;
        logic brownout_trip_select;
        logic low_power_brownout_enable;
        logic ext_reset_enable;
        logic stack_reset_enable;
        logic osc_startup_required;
    } rbs_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } rbs_bus_t;

    typedef struct packed {
        rbs_state_t st;
        logic [POWER_UP_TIMER_W-1:0] cnt;
        logic pin_seen;
        logic wake_hold;
        logic sw_en;
        logic fast;
        logic [NUM_CAUSE-1:0] cause;
        logic [DATA_W-1:0] rdata;
        logic core_reset;
        logic exec_release;
        logic bor_enable;
        logic trip;
        logic bandgap_force;
    } rbs_top_state_t;

    typedef struct packed {
        logic [FILT_W-1:0] cnt;
        logic out;
    } rbs_filt_state_t;

    localparam rbs_top_state_t TOP_RST = '{st: ST_HARD, cnt: '0, pin_seen: 1'b0, wake_hold: 1'b0,
        sw_en: CTRL_SW_EN_RST, fast: CTRL_FAST_RST, cause: CAUSE_RST, rdata: '0, core_reset: 1'b1,
        exec_release: 1'b0, bor_enable: 1'b0, trip: 1'b0, bandgap_force: 1'b0};
    localparam rbs_filt_state_t FILT_RST = '{cnt: '0, out: 1'b0};

endpackage

// ==== rbs_filter.sv ====
`timescale 1ns/1ps
module rbs_filter
    import rbs_pkg::*;
#(
    parameter int unsigned DELAY = BOR_FILTER_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic in_level,
    output logic out_level
);

    // ----------------------------------------------------------------
    // Sustained-level filter
    // ----------------------------------------------------------------
    rbs_filt_state_t s_q;
    rbs_filt_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (!in_level) begin
            s_d.cnt = '0;
            s_d.out = 1'b0;
        end else if (s_q.cnt == FILT_W'(DELAY)) begin
            s_d.out = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= FILT_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign out_level = s_q.out;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset || !ce);

    a_filter_drop: assert property (!in_level |=> !out_level) // [R8]
        else $error("filter output held after input fell");
    a_filter_wait: assert property ($rose(out_level) |-> $past(s_q.cnt) == FILT_W'(DELAY)) // [R8]
        else $error("filter fired before delay");

endmodule

// ==== rbs_analog_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Supply detectors and brown-out comparator
// ----------------------------------------------------------------
module rbs_analog_model
    import rbs_pkg::*;
#(
    parameter int unsigned READY_DLY = 4
) (
    input wire logic sys_clk,
    input wire logic supply_up,
    input wire logic supply_dip,
    input wire logic slow,
    input wire logic brownout_enable,
    output logic por_ok,
    output logic brownout_below,
    output logic brownout_circuit_ready
);
    int unsigned cnt_q = 0;
    logic tog_q = 1'b0;
    always_ff @(posedge sys_clk) begin
        cnt_q <= (brownout_enable && !slow) ? ((cnt_q < READY_DLY) ? cnt_q + 1 : cnt_q) : 0;
        tog_q <= ~tog_q;
    end
    assign por_ok = supply_up;
    assign brownout_circuit_ready = (cnt_q == READY_DLY);
    // Comparator output is meaningless until the circuit is up
    assign brownout_below = brownout_circuit_ready ? supply_dip : tog_q;
endmodule

// ==== rbs_sequencer_bench.sv ====
`timescale 1ns/1ps
module rbs_sequencer_bench;
    import rbs_pkg::*;
    localparam int unsigned PLEN = 20;
    localparam int unsigned FLEN = 3;
    typedef struct packed {
        logic [1:0] mode;
        logic slow;
        logic exp;
    } rbs_row_t;
    localparam rbs_row_t ROWS [6] = '{'{2'h3, 1'b0, 1'b1}, '{2'h3, 1'b1, 1'b0}, '{2'h2, 1'b1, 1'b0},
        '{2'h2, 1'b0, 1'b1}, '{2'h1, 1'b1, 1'b1}, '{2'h0, 1'b1, 1'b1}};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic supply_up = 1'b0;
    logic supply_dip = 1'b0;
    logic slow = 1'b0;
    logic sleep_active = 1'b0;
    logic osc_done = 1'b1;
    logic por_ok, below, ready, core_reset, exec_release, bor_en, trip, bandgap;
    logic [DATA_W-1:0] rd_data, d;
    rbs_src_t src_drv = 9'h020;
    rbs_src_t src;
    rbs_cfg_t cfg = '{power_up_timer_enable_n: 1'b1, low_power_brownout_enable: 1'b1,
        ext_reset_enable: 1'b1, stack_reset_enable: 1'b1, default: '0};
    rbs_bus_t bus = '0;
    int n_fail = 0;
    int n_tests = 0;
    int n;
    always #50 sys_clk = ~sys_clk;
    always_comb begin
        src = src_drv;
        src.por_ok = por_ok;
        src.brownout_below = below;
    end
    rbs_analog_model rbs_analog_model_i (.sys_clk(sys_clk), .supply_up(supply_up), .supply_dip(supply_dip),
        .slow(slow), .brownout_enable(bor_en), .por_ok(por_ok), .brownout_below(below),
        .brownout_circuit_ready(ready));
    rbs_sequencer #(.POWER_UP_TIMER_LEN(PLEN), .FILTER_LEN(FLEN)) rbs_sequencer_i (.sys_clk(sys_clk), .reset(reset),
        .ce(1'b1), .src(src), .cfg(cfg), .brownout_circuit_ready(ready), .osc_startup_done(osc_done),
        .sleep_active(sleep_active), .bus(bus), .rd_data(rd_data), .core_reset(core_reset),
        .exec_release(exec_release), .brownout_enable(bor_en), .brownout_trip_level(trip),
        .bandgap_force(bandgap));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        @(negedge sys_clk);
        v = rd_data;
        @(posedge sys_clk);
    endtask
    task automatic wait_rel(output int cnt);
        cnt = 0;
        @(negedge sys_clk);
        while (exec_release !== 1'b1 && cnt < 100) begin
            cnt++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
    endtask
    task automatic restart(input logic [1:0] mode, input logic power_up_timer_n);
        reset <= 1'b1;
        supply_up <= 1'b0;
        cfg.brownout_mode_field <= mode;
        cfg.power_up_timer_enable_n <= power_up_timer_n;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("core_reset in reset", 8'h01, 8'(core_reset));
        @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        supply_up <= 1'b1;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        restart(2'h0, 1'b1);
        rd(ADDR_BOR_CTRL, d);
        chk("ctrl reset", 8'h80, d);
        rd(ADDR_CAUSE, d);
        chk("cause reset", 8'h01, d);
        rd(4'hf, d);
        chk("unmapped read", 8'h00, d);
        $display("test reset done");
        foreach (ROWS[i]) begin
            slow <= ROWS[i].slow;
            restart(ROWS[i].mode, 1'b1);
            repeat (40) @(negedge sys_clk);
            chk("exec_release by mode", 8'(ROWS[i].exp), 8'(exec_release));
            @(posedge sys_clk);
        end
        slow <= 1'b0;
        $display("test modes done");
        restart(2'h0, 1'b0);
        wait_rel(n);
        chk("timer span", 8'h01, 8'(n >= PLEN && n <= PLEN + 6));
        restart(2'h0, 1'b1);
        wait_rel(n);
        chk("timer off span", 8'h01, 8'(n <= 4));
        cfg.osc_startup_required <= 1'b1;
        osc_done <= 1'b0;
        restart(2'h0, 1'b1);
        repeat (20) @(negedge sys_clk);
        chk("held by oscillator", 8'h00, 8'(exec_release));
        @(posedge sys_clk);
        osc_done <= 1'b1;
        wait_rel(n);
        chk("oscillator release", 8'h01, 8'(n <= 2));
        cfg.osc_startup_required <= 1'b0;
        $display("test timer done");
        restart(2'h3, 1'b1);
        wait_rel(n);
        wr(ADDR_CAUSE, 8'hff);
        supply_dip <= 1'b1;
        repeat (FLEN) @(posedge sys_clk);
        supply_dip <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk("short dip", 8'h00, 8'(core_reset));
        @(posedge sys_clk);
        supply_dip <= 1'b1;
        repeat (FLEN + 6) @(negedge sys_clk);
        chk("long dip", 8'h01, 8'(core_reset));
        @(posedge sys_clk);
        supply_dip <= 1'b0;
        wait_rel(n);
        rd(ADDR_CAUSE, d);
        chk("cause brown-out", 8'h02, d);
        for (int k = 1; k <= 6; k++) begin
            wr(ADDR_CAUSE, 8'hff);
            src_drv[k] <= ~src_drv[k];
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk("core_reset on source", 8'h01, 8'(core_reset));
            @(posedge sys_clk);
            src_drv[k] <= ~src_drv[k];
            wait_rel(n);
            rd(ADDR_CAUSE, d);
            chk("cause bit", 8'h01 << (7 - k), d);
        end
        $display("test sources done");
        src_drv.external_reset_pin_n <= 1'b0;
        restart(2'h0, 1'b1);
        repeat (30) @(negedge sys_clk);
        chk("held by pin", 8'h00, 8'(exec_release));
        @(posedge sys_clk);
        src_drv.external_reset_pin_n <= 1'b1;
        wait_rel(n);
        chk("pin delay", 8'h01, 8'(n >= PIN_DELAY_CYCLES && n <= PIN_DELAY_CYCLES + 3));
        $display("test pin done");
        restart(2'h2, 1'b1);
        wait_rel(n);
        sleep_active <= 1'b1;
        repeat (8) @(posedge sys_clk);
        slow <= 1'b1;
        sleep_active <= 1'b0;
        repeat (8) @(negedge sys_clk);
        chk("wake held", 8'h00, 8'(exec_release));
        @(posedge sys_clk);
        slow <= 1'b0;
        wait_rel(n);
        chk("wake after ready", 8'h01, 8'(n <= 8));
        restart(2'h3, 1'b1);
        wait_rel(n);
        sleep_active <= 1'b1;
        repeat (8) @(posedge sys_clk);
        sleep_active <= 1'b0;
        wait_rel(n);
        chk("wake undelayed", 8'h01, 8'(n <= 1));
        $display("test sleep done");
        restart(2'h1, 1'b1);
        wait_rel(n);
        cfg.brownout_trip_select <= 1'b1;
        wr(ADDR_BOR_CTRL, 8'h40);
        repeat (6) @(negedge sys_clk);
        chk("trip level", 8'h01, 8'(trip));
        chk("software off", 8'h00, 8'(bor_en));
        chk("fast start", 8'h01, 8'(bandgap));
        @(posedge sys_clk);
        rd(ADDR_BOR_CTRL, d);
        chk("ctrl readback", 8'h40, d);
        sleep_active <= 1'b1;
        wr(ADDR_BOR_CTRL, 8'hc0);
        repeat (8) @(negedge sys_clk);
        chk("sleep keeps enable", 8'h01, 8'(bor_en));
        @(posedge sys_clk);
        rd(ADDR_BOR_CTRL, d);
        chk("ready reflected", 8'hc1, d);
        $display("test control done");
        close_out();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        $display("[ERR] watchdog expected done seen hung");
        close_out();
    end
endmodule
